// ---- bench/rie_core_model.sv ----
// Core-side partner: answers push and vector requests after a delay.
// Assumes the bench drives instruction boundaries itself.
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// Core request responder
// ***************************************************************
module rie_core_model
(
    input  wire logic        sys_clk,
    input  wire logic        push_req,
    input  wire logic        vec_req,
    input  wire logic [15:0] vec_addr,
    input  wire logic [3:0]  lat,
    output logic             core_done,
    output logic [15:0]      fetched
);
    logic [3:0] wait_cnt = 4'h0;

    // One-cycle done pulse after lat cycles; a fresh request waits again
    always @(negedge sys_clk)
    begin
        if ((push_req | vec_req) && !core_done && (wait_cnt + 4'h1 < lat))
        begin
            wait_cnt  <= wait_cnt + 4'h1;
            core_done <= 1'b0;
        end
        else if ((push_req | vec_req) && !core_done)
        begin
            wait_cnt  <= 4'h0;
            core_done <= 1'b1;
        end
        else
        begin
            wait_cnt  <= 4'h0;
            core_done <= 1'b0;
        end
    end

    // Record the word address the unit fetched from
    always @(posedge sys_clk)
        if (vec_req && core_done)
            fetched <= vec_addr;
endmodule : rie_core_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the reset and interrupt exception unit.
// Assumes the unit and the core partner model are compiled first.
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// Bench top
// ***************************************************************
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        mode_pin_hi = 1'b0;
    logic        mode_pin_lo = 1'b0;
    logic        nmi_pin = 1'b1;
    logic [7:0]  ext_req_n = 8'hff;
    logic [18:0] int_req = 19'h0;
    logic        nonmaskable_edge_select = 1'b0;
    logic [7:0]  ext_sense_edge = 8'h00;
    logic [7:0]  ext_enable = 8'h00;
    logic        insn_end = 1'b0;
    logic        ccr_instr = 1'b0;
    logic        ccr_mask_clear = 1'b0;
    logic        return_from_exception = 1'b0;
    logic        restored_mask = 1'b0;
    logic        core_done;
    logic        mode_stat_hi, mode_stat_lo, ccr_mask, periph_init, core_run;
    logic        push_req, vec_req;
    logic [15:0] vec_addr, fetched;
    logic [4:0]  vec_num;
    logic [3:0]  lat = 4'h1;
    int          fail_count = 0;
    int          checks_done = 0;

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    rie_unit DUT (.sys_clk, .rstn, .mode_pin_hi, .mode_pin_lo, .nmi_pin,
        .ext_req_n, .int_req, .nonmaskable_edge_select, .ext_sense_edge,
        .ext_enable, .insn_end, .ccr_instr, .ccr_mask_clear,
        .return_from_exception, .restored_mask, .core_done, .mode_stat_hi,
        .mode_stat_lo, .ccr_mask, .periph_init, .core_run, .push_req,
        .vec_req, .vec_addr, .vec_num);

    rie_core_model core (.sys_clk, .push_req, .vec_req, .vec_addr, .lat,
        .core_done, .fetched);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("errors %0d in %0d checks", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // One instruction boundary, optionally a mask-changing instruction
    task automatic step(input logic c);
        @(negedge sys_clk);
        insn_end = 1'b1;
        ccr_instr = c;
        @(negedge sys_clk);
        insn_end = 1'b0;
        ccr_instr = 1'b0;
    endtask : step

    task automatic clr();
        @(negedge sys_clk);
        ccr_mask_clear = 1'b1;
        @(negedge sys_clk);
        ccr_mask_clear = 1'b0;
    endtask : clr

    // Follow one accepted interrupt through push and vector fetch
    task automatic serve(input logic [4:0] v);
        int n = 0;
        chk(16'(push_req), 16'h1);
        chk(16'(vec_num), 16'(v));
        while (!core_run && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(fetched, 16'({v, 1'b0}));
        chk(16'(ccr_mask), 16'h1);
        chk(16'(n < 20), 16'h1);
    endtask : serve

    task automatic do_reset(input logic hi, input logic lo);
        int n = 0;
        @(negedge sys_clk);
        rstn = 1'b0;
        mode_pin_hi = hi;
        mode_pin_lo = lo;
        #1;
        chk(16'(core_run), 16'h0);
        chk(16'(push_req | vec_req), 16'h0);
        chk(16'(ccr_mask), 16'h1);
        chk(16'(periph_init), 16'h1);
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        while (!core_run && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(fetched, 16'h0);
        chk(16'(periph_init), 16'h0);
        chk(16'(ccr_mask), 16'h1);
        chk({14'h0, mode_stat_hi, mode_stat_lo}, {14'h0, hi, lo});
    endtask : do_reset

    // Pending edge is held off until the first instruction completes
    task automatic t_first();
        nmi_pin = 1'b0;
        step(1'b0);
        chk(16'(push_req), 16'h0);
        step(1'b0);
        serve(5'h03);
    endtask : t_first

    task automatic t_mask();
        int_req = 19'h1;
        step(1'b0);
        chk(16'(push_req), 16'h0);
        clr();
        step(1'b1);
        chk(16'(push_req), 16'h0);
        step(1'b0);
        serve(5'h0c);
    endtask : t_mask

    // Internal then external sources, each against all lower ones of its own group
    task automatic t_prio();
        lat = 4'h3;
        for (int i = 0; i < 19; i++)
        begin
            int_req = 19'h7ffff << i;
            clr();
            step(1'b0);
            serve(5'(12 + i));
        end
        ext_enable = 8'hff;
        for (int i = 0; i < 8; i++)
        begin
            ext_req_n = ~(8'hff << i);
            clr();
            step(1'b0);
            serve(5'(4 + i));
        end
        int_req = 19'h0;
        ext_enable = 8'h00;
        ext_req_n = 8'h00;
        clr();
        step(1'b0);
        chk(16'(push_req), 16'h0);
        ext_req_n = 8'hff;
        lat = 4'h1;
    endtask : t_prio

    task automatic t_edge();
        ext_sense_edge = 8'hff;
        ext_enable = 8'h04;
        @(negedge sys_clk);
        return_from_exception = 1'b1;
        restored_mask = 1'b1;
        @(negedge sys_clk);
        return_from_exception = 1'b0;
        chk(16'(ccr_mask), 16'h1);
        ext_req_n = 8'hf3;
        @(negedge sys_clk);
        ext_req_n = 8'hff;
        clr();
        step(1'b0);
        serve(5'h06);
        clr();
        step(1'b0);
        chk(16'(push_req), 16'h0);
    endtask : t_edge

    task automatic t_nmi();
        nonmaskable_edge_select = 1'b1;
        nmi_pin = 1'b1;
        step(1'b0);
        serve(5'h03);
        nmi_pin = 1'b0;
        step(1'b0);
        chk(16'(push_req), 16'h0);
        nmi_pin = 1'b1;
        step(1'b0);
        chk(16'(push_req), 16'h1);
        do_reset(1'b0, 1'b1);
    endtask : t_nmi

    // Main sequence
    initial
    begin
        do_reset(1'b1, 1'b0);
        t_first();
        t_mask();
        t_prio();
        t_edge();
        t_nmi();
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire

// ---- rtl/rie_params.svh ----
// Constants for the reset and interrupt exception unit.
// Assumes inclusion by the unit; definitions only.
`ifndef RIE_PARAMS_SVH
`define RIE_PARAMS_SVH

// ***************************************************************
// Vector numbers and table layout
// ***************************************************************
`define RIE_VEC_RESET     5'h00
`define RIE_VEC_NMI       5'h03
`define RIE_VEC_EXT0      5'h04
`define RIE_VEC_INT0      5'h0c
`define RIE_VEC_LAST      5'h1e
`define RIE_TABLE_END     16'h003d
`define RIE_NUM_EXT       8
`define RIE_NUM_INT       19

// ***************************************************************
// Reset values and the cleared mask value
// ***************************************************************
`define RIE_MASK_SET      1'b1
`define RIE_NMI_EDGE_RST  1'b0
`define RIE_IRQ_REG_RST   8'h00
`define RIE_MODE_RST      2'h0
`define RIE_NMI_IDLE      1'b1
`define RIE_EXT_IDLE      8'hff
`define RIE_MASK_CLR      1'b0

`endif

// ---- rtl/rie_pkg.sv ----
// Types shared by the exception unit.
// Assumes rie_params.svh supplies the numeric constants.
`default_nettype none
package rie_pkg;

    // Exception sequencer states
    typedef enum logic [2:0]
    {
        RIE_HALT,
        RIE_RST_FETCH,
        RIE_FIRST_INSN,
        RIE_RUN,
        RIE_PUSH,
        RIE_FETCH
    } rie_state_t;

endpackage : rie_pkg
`default_nettype wire

// ---- rtl/rie_unit.sv ----
// Reset and interrupt exception unit: reset sequence, request capture,
// fixed priority selection and vector fetch handshake with the CPU core.
// Assumes the core signals instruction boundaries, performs the stack
// pushes and vector reads on request, and keeps its own register file.
`timescale 1ns/10ps
`default_nettype none
`include "rie_params.svh"

// Functional notes
// RULE1: Reset outranks any pending interrupt.
// RULE2: Everything halts while reset low; sequence starts on release.
// RULE3: Mode pins latched first into mode status bits.
// RULE4: Reset sets the interrupt mask bit.
// RULE5: Reset returns peripheral registers to initial values.
// RULE6: Reset loads PC from vector entry zero.
// RULE7: General registers and RAM untouched by reset.
// RULE8: All interrupts blocked until first instruction completes.
// RULE9: Maskable needs enable bit and cleared mask; int_req checks only the mask.
// RULE10: Reset source holds pin low long enough.
// RULE11: Push PC and CONDITION_CODE_REGISTER before changing them.
// RULE12: Both sequences set mask and fetch vector.
// RULE13: Vector table spans 0x0000 to 0x003D.
// RULE14: Accept only at boundaries, not after CONDITION_CODE_REGISTER instructions.
// RULE15: Mask bit blocks all except nonmaskable.
// RULE16: External requests select falling edge or low level.
// RULE17: Nonmaskable pin edge sensed, either edge selectable.
// RULE18: Twenty-eight sources: nine pins, nineteen internal.
// RULE19: Fixed priority from nonmaskable down to converter.
// RULE20: Free-running timer sources use vectors twelve to eighteen.
// RULE21: Each source has its own vector entry.
// RULE22: Enabled falling edges latched despite mask until serviced.
// RULE23: Edge select zero falling, one rising.
// RULE24: Vector fetch address is twice vector number.
module rie_unit
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        mode_pin_hi,
    input  wire logic        mode_pin_lo,
    input  wire logic        nmi_pin,
    input  wire logic [7:0]  ext_req_n,
    input  wire logic [18:0] int_req,
    input  wire logic        nonmaskable_edge_select,
    input  wire logic [7:0]  ext_sense_edge,
    input  wire logic [7:0]  ext_enable,
    input  wire logic        insn_end,
    input  wire logic        ccr_instr,
    input  wire logic        ccr_mask_clear,
    input  wire logic        return_from_exception,
    input  wire logic        restored_mask,
    input  wire logic        core_done,
    output logic             mode_stat_hi,
    output logic             mode_stat_lo,
    output logic             ccr_mask,
    output logic             periph_init,
    output logic             core_run,
    output logic             push_req,
    output logic             vec_req,
    output logic [15:0]      vec_addr,
    output logic [4:0]       vec_num
);

    // ***********************************************************
    // Reset synchroniser
    // ***********************************************************
    logic rst_meta;
    logic rst_sync_n;

    // Async assert, two-stage release so the sequence begins cleanly
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ***********************************************************
    // Functions
    // ***********************************************************
    // Table entries are words, so entry address is twice the number
    function automatic logic [15:0] rie_vec_to_addr(input logic [4:0] num);
        rie_vec_to_addr = {10'h000, num, 1'b0}; // RULE24 RULE13
    endfunction : rie_vec_to_addr

    // ***********************************************************
    // Request capture
    // ***********************************************************
    rie_pkg::rie_state_t state;
    rie_pkg::rie_state_t next_state;
    logic        nmi_prev;
    logic        next_nmi_prev;
    logic        nmi_pend;
    logic        next_nmi_pend;
    logic [7:0]  ext_prev;
    logic [7:0]  next_ext_prev;
    logic [7:0]  ext_latch;
    logic [7:0]  next_ext_latch;
    logic [7:0]  ext_active;
    logic        nmi_edge;
    logic        svc_ext;
    logic [2:0]  svc_idx;
    logic        svc_nmi;

    // Edge detection; a new edge wins over the clear of the same flag
    always_comb
    begin
        next_nmi_prev  = nmi_pin;
        next_ext_prev  = ext_req_n;
        nmi_edge = nonmaskable_edge_select ? (nmi_pin & ~nmi_prev)   // RULE23 RULE17
                                           : (~nmi_pin & nmi_prev);
        next_nmi_pend  = nmi_pend;
        next_ext_latch = ext_latch;
        if (svc_nmi)
            next_nmi_pend = 1'b0;
        if (svc_ext)
            next_ext_latch[svc_idx] = 1'b0;
        if (nmi_edge)
            next_nmi_pend = 1'b1;
        // Latched even under the mask, but only when enabled
        next_ext_latch = next_ext_latch
                       | (ext_prev & ~ext_req_n & ext_enable & ext_sense_edge); // RULE22
    end

    // Level mode reads the pin directly, so the source must hold it;
    // kept apart from the edge process so no false loop runs via the sequencer
    assign ext_active = ext_enable & ((ext_sense_edge & ext_latch)
                                    | (~ext_sense_edge & ~ext_req_n)); // RULE16 RULE9

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            nmi_prev  <= `RIE_NMI_IDLE;
            nmi_pend  <= 1'b0;
            ext_prev  <= `RIE_EXT_IDLE;
            ext_latch <= `RIE_IRQ_REG_RST;
        end
        else
        begin
            nmi_prev  <= next_nmi_prev;
            nmi_pend  <= next_nmi_pend;
            ext_prev  <= next_ext_prev;
            ext_latch <= next_ext_latch;
        end
    end

    // ***********************************************************
    // Priority selection
    // ***********************************************************
    logic        any_req;
    logic [4:0]  win_num;

    // Lowest vector number wins; each source has its own entry
    always_comb
    begin
        any_req = 1'b0;
        win_num = `RIE_VEC_LAST;
        for (int i = `RIE_NUM_INT - 1; i >= 0; i--)
        begin
            if (int_req[i] && !ccr_mask) // RULE15
            begin
                any_req = 1'b1;
                win_num = `RIE_VEC_INT0 + 5'(i); // RULE20 RULE21 RULE18
            end
        end
        for (int i = `RIE_NUM_EXT - 1; i >= 0; i--)
        begin
            if (ext_active[i] && !ccr_mask) // RULE15
            begin
                any_req = 1'b1;
                win_num = `RIE_VEC_EXT0 + 5'(i); // RULE19
            end
        end
        if (nmi_pend)
        begin
            any_req = 1'b1;
            win_num = `RIE_VEC_NMI; // RULE19
        end
    end

    // ***********************************************************
    // Exception sequencer
    // ***********************************************************
    logic        next_mask;
    logic        next_mode_hi;
    logic        next_mode_lo;
    logic [4:0]  next_vec_num;
    logic        accept;

    // Mode reset value split into its two status bits
    localparam logic [1:0] mode_rst_val = `RIE_MODE_RST;

    // Acceptance waits for a clean boundary after the first instruction
    always_comb
    begin
        next_state   = state;
        next_mask    = ccr_mask;
        next_mode_hi = mode_stat_hi;
        next_mode_lo = mode_stat_lo;
        next_vec_num = vec_num;
        svc_nmi      = 1'b0;
        svc_ext      = 1'b0;
        svc_idx      = 3'(vec_num - `RIE_VEC_EXT0);
        accept       = any_req && insn_end && !ccr_instr; // RULE14
        unique case (state)
            rie_pkg::RIE_HALT:
            begin
                // Mode pins caught as the first step after release
                next_mode_hi = mode_pin_hi; // RULE3
                next_mode_lo = mode_pin_lo;
                next_mask    = `RIE_MASK_SET; // RULE4
                next_vec_num = `RIE_VEC_RESET;
                next_state   = rie_pkg::RIE_RST_FETCH;
            end
            rie_pkg::RIE_RST_FETCH:
            begin
                if (core_done)
                    next_state = rie_pkg::RIE_FIRST_INSN; // RULE6
            end
            rie_pkg::RIE_FIRST_INSN:
            begin
                if (insn_end)
                    next_state = rie_pkg::RIE_RUN; // RULE8
            end
            rie_pkg::RIE_RUN:
            begin
                if (ccr_mask_clear)
                    next_mask = `RIE_MASK_CLR;
                if (return_from_exception)
                    next_mask = restored_mask;
                if (accept)
                begin
                    next_vec_num = win_num;
                    next_state   = rie_pkg::RIE_PUSH;
                end
            end
            rie_pkg::RIE_PUSH:
            begin
                if (core_done)
                begin
                    next_mask  = `RIE_MASK_SET; // RULE12
                    next_state = rie_pkg::RIE_FETCH;
                    svc_nmi    = (vec_num == `RIE_VEC_NMI);
                    svc_ext    = (vec_num >= `RIE_VEC_EXT0) && (vec_num < `RIE_VEC_INT0);
                end
            end
            rie_pkg::RIE_FETCH:
            begin
                // Sequence ends; the next acceptance waits for a boundary
                if (core_done)
                    next_state = rie_pkg::RIE_RUN;
            end
            default:
                next_state = rie_pkg::RIE_HALT;
        endcase
    end

    // Reset holds everything in halt; registers and RAM of the core are not ours
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state        <= rie_pkg::RIE_HALT; // RULE2 RULE1 RULE7
            ccr_mask     <= `RIE_MASK_SET;
            mode_stat_hi <= mode_rst_val[1];
            mode_stat_lo <= mode_rst_val[0];
            vec_num      <= `RIE_VEC_RESET;
        end
        else
        begin
            state        <= next_state;
            ccr_mask     <= next_mask;
            mode_stat_hi <= next_mode_hi;
            mode_stat_lo <= next_mode_lo;
            vec_num      <= next_vec_num;
        end
    end

    // ***********************************************************
    // Core handshake outputs
    // ***********************************************************
    // Peripherals stay in initial state until the reset vector is read
    assign periph_init = (state == rie_pkg::RIE_HALT) || (state == rie_pkg::RIE_RST_FETCH); // RULE5
    assign core_run    = (state == rie_pkg::RIE_FIRST_INSN) || (state == rie_pkg::RIE_RUN);
    assign push_req    = (state == rie_pkg::RIE_PUSH); // RULE11
    assign vec_req     = (state == rie_pkg::RIE_RST_FETCH) || (state == rie_pkg::RIE_FETCH);
    assign vec_addr    = rie_vec_to_addr(vec_num); // RULE6

    // ***********************************************************
    // Assertions
    // ***********************************************************
    a_push_then_fetch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE11
        (push_req && core_done) |=> vec_req && ccr_mask)
        else $error("Vector fetch did not follow the push");
    a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE15
        (state == rie_pkg::RIE_RUN && next_state == rie_pkg::RIE_PUSH && ccr_mask)
        |-> next_vec_num == `RIE_VEC_NMI)
        else $error("Masked source accepted");
    a_first_insn: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE8
        (state == rie_pkg::RIE_FIRST_INSN) |=> !push_req)
        else $error("Interrupt taken before first instruction");
    a_reset_vec: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE6
        (state == rie_pkg::RIE_RST_FETCH) |-> vec_addr == 16'h0000 && ccr_mask)
        else $error("Reset fetch from wrong entry");
    a_vec_range: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE13
        vec_req |-> vec_addr < `RIE_TABLE_END)
        else $error("Vector outside table");
    a_ccr_defer: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE14
        (state == rie_pkg::RIE_RUN && ccr_instr) |=> !push_req)
        else $error("Accepted after CONDITION_CODE_REGISTER instruction");
    a_nmi_first: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE19
        (state == rie_pkg::RIE_RUN && accept && nmi_pend) |=> vec_num == `RIE_VEC_NMI)
        else $error("NMI lost priority");
    a_mode_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // RULE3
        (state == rie_pkg::RIE_RST_FETCH && $past(state) == rie_pkg::RIE_HALT)
        |-> mode_stat_hi == $past(mode_pin_hi) && mode_stat_lo == $past(mode_pin_lo))
        else $error("Mode pins not latched");
    c_reset_done: cover property (@(posedge sys_clk) state == rie_pkg::RIE_FIRST_INSN);
    c_nmi_taken: cover property (@(posedge sys_clk) push_req && vec_num == `RIE_VEC_NMI);
    c_ext_taken: cover property (@(posedge sys_clk) push_req && vec_num == `RIE_VEC_EXT0);
    c_adc_taken: cover property (@(posedge sys_clk) push_req && vec_num == `RIE_VEC_LAST);

endmodule : rie_unit
`default_nettype wire
